// >>> verilog/vspt_cfg.svh
// constants for the video sync port and trigger block
`ifndef VSPT_CFG_SVH
`define VSPT_CFG_SVH
// ----------------------------------------------------------------
// subaddresses
// ----------------------------------------------------------------
`define VSPT_ADDR_CTRL     8'h6b
`define VSPT_ADDR_TRIG_LO  8'h6c
`define VSPT_ADDR_TRIG_HI  8'h6d
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VSPT_CTRL_RST      8'h00
`define VSPT_TRIG_RST      11'h000
`define VSPT_VTRIG_RST     5'h00
// ----------------------------------------------------------------
// field positions in the upper trigger register
// ----------------------------------------------------------------
`define VSPT_TRIG_HI_MSB   7
`define VSPT_TRIG_HI_LSB   5
`define VSPT_VTRIG_MSB     4
// ----------------------------------------------------------------
// timing counts in pixel clocks, lines and fields
// ----------------------------------------------------------------
`define VSPT_LINE_LEN0     11'h360
`define VSPT_LINE_LEN1     11'h35a
`define VSPT_HSYNC_REF     11'h04f
`define VSPT_HSYNC_WIDTH   11'h040
`define VSPT_VS_LINES      10'h003
`define VSPT_FIELD_SEQUENCE_SYNC_NTSC     4'h4
`define VSPT_FIELD_SEQUENCE_SYNC_PAL      4'h8
`define VSPT_FIELD_SEQUENCE_SYNC_SECAM    4'hc
`endif

// >>> verilog/vspt_pkg.sv
// types for the video sync port and trigger block
`default_nettype none
package vspt_pkg;
   // signal type carried on the first reference port
   typedef enum logic [1:0] {
      VSPT_PER_FIELD_VERTICAL_SYNC,
      VSPT_ODD_EVEN_FRAME_SYNC,
      VSPT_FIELD_SEQUENCE_SYNC,
      VSPT_TYPE_UNUSED
   } vspt_port_a_type_t;

   // port control register layout, msb first
   typedef struct packed {
      vspt_port_a_type_t port_a_type;
      logic              hsync_source_sel;
      logic              port_a_direction;
      logic              port_a_polarity;
      logic              port_b_blanking_mode;
      logic              port_b_direction;
      logic              port_b_polarity;
   } vspt_ctrl_t;

   // settings held in neighbouring registers outside this block
   typedef struct packed {
      logic        embedded_sync_select;
      logic        line_length_select;
      logic        pal;
      logic        secam;
      logic [9:0]  lines_per_field;
      logic [9:0]  first_active_line;
      logic [9:0]  last_active_line;
      logic [10:0] port_b_pulse_start;
      logic [10:0] port_b_pulse_end;
   } vspt_timing_cfg_t;
endpackage
`default_nettype wire

// >>> verilog/vspt_top.sv
// reference port control and horizontal trigger timing
`default_nettype none
`include "vspt_cfg.svh"

module vspt_top (
   // clock and reset
   input  wire logic                      mclk,
   input  wire logic                      rst_b,
   // subaddress register port
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   input  wire logic [7:0]                reg_addr,
   input  wire logic [7:0]                reg_wdata,
   output logic      [7:0]                reg_rdata,
   // settings from neighbouring registers
   input  wire vspt_pkg::vspt_timing_cfg_t timing_cfg,
   input  wire logic                      embedded_frame_sync,
   // first reference port
   input  wire logic                      port_a_in,
   output logic                           port_a_out,
   output logic                           port_a_oe,
   // second reference port
   input  wire logic                      port_b_in,
   output logic                           port_b_out,
   output logic                           port_b_oe,
   // internal timing
   output logic                           hsync_out,
   output logic                           internal_blank_n,
   output logic      [10:0]               h_count,
   output logic      [9:0]                line_count
);
   import vspt_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic active_edge(input logic prev, input logic cur, input logic pol);
      active_edge = (prev != cur) && (cur == ~pol);
   endfunction

   function automatic logic in_range11(input logic [10:0] v, input logic [10:0] lo,
                                       input logic [10:0] hi);
      in_range11 = (v >= lo) && (v < hi);
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   vspt_ctrl_t  ctrl_r;
   logic [10:0] horizontal_trigger_phase_r;
   logic [4:0]  vtrig_r;
   logic [7:0]  rdata_r;

   wire wr_ctrl = reg_wr && (reg_addr == `VSPT_ADDR_CTRL);
   wire wr_lo   = reg_wr && (reg_addr == `VSPT_ADDR_TRIG_LO);
   wire wr_hi   = reg_wr && (reg_addr == `VSPT_ADDR_TRIG_HI);

   // codes above the line length are not guarded here; software keeps them in range
   wire [7:0] rdata_nxt =
      (reg_addr == `VSPT_ADDR_CTRL)    ? ctrl_r :
      (reg_addr == `VSPT_ADDR_TRIG_LO) ? horizontal_trigger_phase_r[7:0] :
      (reg_addr == `VSPT_ADDR_TRIG_HI) ? {horizontal_trigger_phase_r[10:8], vtrig_r} : 8'h00;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r  <= vspt_ctrl_t'(`VSPT_CTRL_RST);
         horizontal_trigger_phase_r <= `VSPT_TRIG_RST;
         vtrig_r <= `VSPT_VTRIG_RST;
         rdata_r <= 8'h00;
      end else begin
         if (wr_ctrl)
            ctrl_r <= vspt_ctrl_t'(reg_wdata);
         if (wr_lo)
            horizontal_trigger_phase_r[7:0] <= reg_wdata;
         if (wr_hi) begin
            horizontal_trigger_phase_r[10:8] <= reg_wdata[`VSPT_TRIG_HI_MSB:`VSPT_TRIG_HI_LSB];
            vtrig_r       <= reg_wdata[`VSPT_VTRIG_MSB:0];
         end
         if (reg_rd)
            rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // input synchronisers and edge detect
   // ----------------------------------------------------------------
   // three stages per pin; a level counts only once stages two and three agree
   logic [2:0] sync_a_r;
   logic [2:0] sync_b_r;
   logic       level_a_r;
   logic       level_b_r;
   logic       prev_a_r;
   logic       prev_b_r;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync_a_r  <= 3'h0;
         sync_b_r  <= 3'h0;
         level_a_r <= 1'b0;
         level_b_r <= 1'b0;
         prev_a_r  <= 1'b0;
         prev_b_r  <= 1'b0;
      end else begin
         sync_a_r <= {sync_a_r[1:0], port_a_in};
         sync_b_r <= {sync_b_r[1:0], port_b_in};
         if (sync_a_r[1] == sync_a_r[2])
            level_a_r <= sync_a_r[2];
         if (sync_b_r[1] == sync_b_r[2])
            level_b_r <= sync_b_r[2];
         prev_a_r <= level_a_r;
         prev_b_r <= level_b_r;
      end
   end

   // polarity bit picks rising or falling edge; only meaningful while the port is an input
   wire edge_a = !ctrl_r.port_a_direction &&
                 active_edge(prev_a_r, level_a_r, ctrl_r.port_a_polarity);
   wire edge_b = !ctrl_r.port_b_direction &&
                 active_edge(prev_b_r, level_b_r, ctrl_r.port_b_polarity);

   // ----------------------------------------------------------------
   // trigger source selection
   // ----------------------------------------------------------------
   wire emb      = timing_cfg.embedded_sync_select;
   wire trig_a   = !ctrl_r.hsync_source_sel && (emb ? embedded_frame_sync : edge_a);
   wire trig_b   = ctrl_r.hsync_source_sel && !emb && edge_b;
   wire trig_h   = trig_a || trig_b;
   wire vtrig_ev = edge_a && (ctrl_r.port_a_type != VSPT_TYPE_UNUSED);

   // ----------------------------------------------------------------
   // horizontal and vertical counters
   // ----------------------------------------------------------------
   logic [10:0] h_cnt_r;
   logic [9:0]  line_r;
   logic        field_r;
   logic [3:0]  field_sequence_sync_r;

   wire [10:0] line_len = timing_cfg.line_length_select ? `VSPT_LINE_LEN1 : `VSPT_LINE_LEN0;
   wire        h_wrap   = (h_cnt_r == line_len - 11'h001);
   wire        v_wrap   = (line_r == timing_cfg.lines_per_field - 10'h001);
   wire [3:0]  field_sequence_sync_len = timing_cfg.secam ? `VSPT_FIELD_SEQUENCE_SYNC_SECAM :
                          timing_cfg.pal   ? `VSPT_FIELD_SEQUENCE_SYNC_PAL   : `VSPT_FIELD_SEQUENCE_SYNC_NTSC;
   // loading the trigger code moves the whole timing earlier as the code grows
   wire [10:0] h_cnt_nxt = trig_h ? horizontal_trigger_phase_r : (h_wrap ? 11'h000 : h_cnt_r + 11'h001);
   wire        line_step = h_wrap && !trig_h;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         h_cnt_r <= 11'h000;
         line_r  <= 10'h000;
         field_r <= 1'b0;
         field_sequence_sync_r  <= 4'h0;
      end else begin
         h_cnt_r <= h_cnt_nxt;
         if (vtrig_ev)
            line_r <= {5'h00, vtrig_r};
         else if (line_step)
            line_r <= v_wrap ? 10'h000 : line_r + 10'h001;
         if (line_step && v_wrap) begin
            field_r <= ~field_r;
            field_sequence_sync_r  <= (field_sequence_sync_r >= field_sequence_sync_len - 4'h1) ? 4'h0 : field_sequence_sync_r + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // output pulse generation
   // ----------------------------------------------------------------
   wire vs_act   = (line_r < `VSPT_VS_LINES);
   wire act_line = (line_r >= timing_cfg.first_active_line) &&
                   (line_r <= timing_cfg.last_active_line);
   wire b_win    = in_range11(h_cnt_r, timing_cfg.port_b_pulse_start,
                              timing_cfg.port_b_pulse_end);
   wire hs_act   = in_range11(h_cnt_r, `VSPT_HSYNC_REF, `VSPT_HSYNC_REF + `VSPT_HSYNC_WIDTH);
   logic a_act;

   always_comb begin
      case (ctrl_r.port_a_type)
         VSPT_PER_FIELD_VERTICAL_SYNC: a_act = vs_act;
         VSPT_ODD_EVEN_FRAME_SYNC:     a_act = !field_r;
         VSPT_FIELD_SEQUENCE_SYNC:     a_act = vs_act && (field_sequence_sync_r == 4'h0);
         default:                      a_act = 1'b0;
      endcase
   end

   // blanking-not mode drops the pulse outside active lines
   wire b_act    = ctrl_r.port_b_blanking_mode ? (b_win && act_line) : b_win;
   // a blanking input is only honoured when embedded sync is off
   wire b_blank  = ctrl_r.port_b_blanking_mode && !ctrl_r.port_b_direction && !emb;
   wire blank_nxt = b_blank ? (level_b_r ^ ctrl_r.port_b_polarity) : (act_line && b_win);

   logic a_out_r;
   logic a_oe_r;
   logic b_out_r;
   logic b_oe_r;
   logic hs_r;
   logic blank_n_r;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         a_out_r   <= 1'b0;
         a_oe_r    <= 1'b0;
         b_out_r   <= 1'b0;
         b_oe_r    <= 1'b0;
         hs_r      <= 1'b0;
         blank_n_r <= 1'b0;
      end else begin
         a_out_r   <= a_act ^ ctrl_r.port_a_polarity;
         a_oe_r    <= ctrl_r.port_a_direction;
         b_out_r   <= b_act ^ ctrl_r.port_b_polarity;
         b_oe_r    <= ctrl_r.port_b_direction;
         hs_r      <= hs_act;
         blank_n_r <= blank_nxt;
      end
   end

   assign port_a_out       = a_out_r;
   assign port_a_oe        = a_oe_r;
   assign port_b_out       = b_out_r;
   assign port_b_oe        = b_oe_r;
   assign hsync_out        = hs_r;
   assign internal_blank_n = blank_n_r;
   assign h_count          = h_cnt_r;
   assign line_count       = line_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   ctrl_hold_a: assert property (!wr_ctrl |=> $stable(ctrl_r))
      else $error("port control changed without a write");
   trig_load_a: assert property (trig_h |=> h_count == $past(horizontal_trigger_phase_r))
      else $error("trigger edge did not load the trigger code");
   hsync_ref_a: assert property (h_cnt_r == `VSPT_HSYNC_REF |=> hsync_out)
      else $error("hsync leading slope not at reference count");
   line_len_a: assert property (h_wrap && !trig_h |=> h_count == 11'h000)
      else $error("line did not wrap at programmed length");
   port_b_src_a: assert property (edge_b && ctrl_r.hsync_source_sel && !emb
                                  |=> h_count == $past(horizontal_trigger_phase_r))
      else $error("second port edge ignored as hsync source");
   a_dir_a: assert property ($changed(ctrl_r.port_a_direction)
                             |=> port_a_oe == $past(ctrl_r.port_a_direction))
      else $error("first port enable does not follow direction");
   b_dir_a: assert property ($changed(ctrl_r.port_b_direction)
                             |=> port_b_oe == $past(ctrl_r.port_b_direction))
      else $error("second port enable does not follow direction");
   horizontal_reference_pulse_out_a: assert property (!ctrl_r.port_b_blanking_mode && b_win
                                |=> port_b_out == !$past(ctrl_r.port_b_polarity))
      else $error("reference pulse missing in window");
   cblank_out_a: assert property (ctrl_r.port_b_blanking_mode && !act_line
                                  |=> port_b_out == $past(ctrl_r.port_b_polarity))
      else $error("blanking pulse present in vertical blanking");
   vs_out_a: assert property (ctrl_r.port_a_type == VSPT_PER_FIELD_VERTICAL_SYNC && vs_act
                              |=> port_a_out == !$past(ctrl_r.port_a_polarity))
      else $error("vertical sync not driven on first port");
   hi_read_a: assert property (reg_rd && reg_addr == `VSPT_ADDR_TRIG_HI
                               |=> reg_rdata[7:5] == $past(horizontal_trigger_phase_r[10:8]))
      else $error("upper trigger bits read back wrong");
   sync_lat_a: assert property ($rose(level_a_r) |-> $past(sync_a_r[2]) && $past(sync_a_r[1]))
      else $error("first port level changed before stages agreed");

   trig_seen_c: cover property (trig_h ##1 h_cnt_r == horizontal_trigger_phase_r);
   b_pulse_c:   cover property (port_b_oe && $rose(port_b_out));
   field_sequence_sync_c:      cover property (ctrl_r.port_a_type == VSPT_FIELD_SEQUENCE_SYNC && port_a_out);
   blank_in_c:  cover property (b_blank && $fell(internal_blank_n));
endmodule
`default_nettype wire

// >>> testbench/vspt_sync_src.sv
// far-side sync source model driving the two reference port pins
`default_nettype none
module vspt_sync_src (
   // clock
   input  wire logic mclk,
   // pulse requests and polarity from the bench
   input  wire logic fire_a,
   input  wire logic fire_b,
   input  wire logic pol_a,
   input  wire logic pol_b,
   // device drive of the pins
   input  wire logic dev_a,
   input  wire logic oe_a,
   input  wire logic dev_b,
   input  wire logic oe_b,
   // resolved pin levels
   output logic      pin_a,
   output logic      pin_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_a_r = 3'h0;
   logic [2:0] cnt_b_r = 3'h0;
   // ----------------------------------------------------------------
   // pulse generation
   // ----------------------------------------------------------------
   // six-cycle pulses, long enough to pass the device input stages
   always_ff @(posedge mclk) begin
      cnt_a_r <= fire_a ? 3'h6 : (cnt_a_r != 3'h0 ? cnt_a_r - 3'h1 : 3'h0);
      cnt_b_r <= fire_b ? 3'h6 : (cnt_b_r != 3'h0 ? cnt_b_r - 3'h1 : 3'h0);
   end
   // idle sits at the inactive level, so a polarity change made after the
   // device has switched never shows an active edge
   assign pin_a = oe_a ? dev_a : ((cnt_a_r != 3'h0) ^ pol_a);
   assign pin_b = oe_b ? dev_b : ((cnt_b_r != 3'h0) ^ pol_b);
endmodule
`default_nettype wire

// >>> testbench/video_sync_port_trigger_test.sv
// self-checking bench for the sync port and trigger block
`default_nettype none
`include "vspt_cfg.svh"
module video_sync_port_trigger_test;
   timeunit 1ns;
   timeprecision 1ps;
   import vspt_pkg::*;
   logic             mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, efs = 1'b0;
   logic             fire_a = 1'b0, fire_b = 1'b0, pol_a = 1'b0, pol_b = 1'b0;
   logic [7:0]       reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic             pin_a, pin_b, a_out, a_oe, b_out, b_oe, hs, blank_n;
   logic [10:0]      h_count;
   logic [9:0]       line_count;
   vspt_timing_cfg_t cfg;
   int               n_mismatch = 0, total_checks = 0;
   vspt_top u_dut (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timing_cfg(cfg),
      .embedded_frame_sync(efs), .port_a_in(pin_a), .port_a_out(a_out), .port_a_oe(a_oe),
      .port_b_in(pin_b), .port_b_out(b_out), .port_b_oe(b_oe), .hsync_out(hs),
      .internal_blank_n(blank_n), .h_count(h_count), .line_count(line_count));
   vspt_sync_src u_src (.mclk(mclk), .fire_a(fire_a), .fire_b(fire_b), .pol_a(pol_a),
      .pol_b(pol_b), .dev_a(a_out), .oe_a(a_oe), .dev_b(b_out), .oe_b(b_oe),
      .pin_a(pin_a), .pin_b(pin_b));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   // step off the edge first so the counters are read once they have settled
   task automatic wait_h(input logic [10:0] v);
      #1;
      for (int i = 0; i < 2000 && h_count !== v; i++) tick(1);
   endtask
   task automatic wait_line(input logic [9:0] v);
      #1;
      for (int i = 0; i < 10000 && line_count !== v; i++) tick(1);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // fires one edge from the far side well away from the code, then expects
   // the counter to jump to the code, or to keep counting when refused
   task automatic trig(input logic [7:0] ctrl, input logic b, input logic [10:0] code,
                       input logic load);
      logic [10:0] h0;
      int          i;
      wr(`VSPT_ADDR_CTRL, ctrl);
      wr(`VSPT_ADDR_TRIG_LO, code[7:0]);
      wr(`VSPT_ADDR_TRIG_HI, {code[10:8], 5'h03});
      @(posedge mclk);
      pol_a <= ctrl[3];
      pol_b <= ctrl[0];
      wait_h(11'h1f4);
      @(posedge mclk);
      if (b) fire_b <= 1'b1;
      else fire_a <= 1'b1;
      @(posedge mclk);
      fire_a <= 1'b0;
      fire_b <= 1'b0;
      #1 h0 = h_count;
      for (i = 0; i < 12 && h_count !== code; i++) tick(1);
      check({5'h00, h_count}, {5'h00, load ? code : h0 + 11'h00c});
      if (!b) check({6'h00, line_count}, 16'h0003);
      if (load) begin
         for (i = 0; i < 1000 && hs !== 1'b1; i++) tick(1);
         // a code inside the sync window lands mid-pulse, so sync shows at once
         if (code >= `VSPT_HSYNC_REF && code < `VSPT_HSYNC_REF + `VSPT_HSYNC_WIDTH)
            check(16'(i), 16'h0001);
         else
            check(16'(i), 16'((`VSPT_LINE_LEN0 + `VSPT_HSYNC_REF - code) % `VSPT_LINE_LEN0
                              + 11'h001));
      end
      $display("test trig ctrl=%h done", ctrl);
   endtask
   task automatic pb(input logic [7:0] ctrl, input logic on);
      wr(`VSPT_ADDR_CTRL, ctrl);
      wait_h(11'd200);
      tick(1);
      check({14'h0, b_oe, b_out}, {14'h0, 1'b1, on ^ ctrl[0]});
      wait_h(11'd210);
      tick(1);
      check({15'h0, b_out}, {15'h0, ctrl[0]});
      $display("test port b ctrl=%h done", ctrl);
   endtask
   task automatic pa(input logic [7:0] ctrl, input logic on);
      wr(`VSPT_ADDR_CTRL, ctrl);
      wait_line(10'd1);
      tick(400);
      check({14'h0, a_oe, a_out}, {14'h0, 1'b1, on ^ ctrl[3]});
      wait_line(10'd5);
      tick(400);
      check({15'h0, a_out}, {15'h0, ctrl[3]});
      $display("test port a ctrl=%h done", ctrl);
   endtask
   task automatic len_chk(input logic sel, input logic [10:0] exp);
      int i;
      @(posedge mclk);
      cfg.line_length_select <= sel;
      wait_h(11'h000);
      tick(1);
      for (i = 1; i < 2000 && h_count !== 11'h000; i++) tick(1);
      check(16'(i), {5'h00, exp});
      $display("test line length done");
   endtask
   // decoded embedded frame sync retimes the counter when the first port is selected
   task automatic emb_chk(input logic [10:0] code);
      wr(`VSPT_ADDR_TRIG_LO, code[7:0]);
      wr(`VSPT_ADDR_CTRL, 8'h00);
      @(posedge mclk);
      cfg.embedded_sync_select <= 1'b1;
      wait_h(11'h1f4);
      @(posedge mclk);
      efs <= 1'b1;
      @(posedge mclk);
      efs <= 1'b0;
      #1 check({5'h00, h_count}, {5'h00, code});
      @(posedge mclk);
      cfg.embedded_sync_select <= 1'b0;
      $display("test embedded sync done");
   endtask
   // counts the fields, out of nf, in which the first port is active on line 1
   task automatic pa_cnt(input logic [7:0] ctrl, input int nf, input int exp);
      int n;
      n = 0;
      wr(`VSPT_ADDR_CTRL, ctrl);
      repeat (nf) begin
         wait_line(10'd1);
         tick(100);
         if (a_out === ~ctrl[3]) n++;
         wait_line(10'd3);
      end
      check(16'(n), 16'(exp));
      $display("test port a count ctrl=%h done", ctrl);
   endtask
   // second port as blanking input: its level becomes the internal blanking
   task automatic blk();
      wr(`VSPT_ADDR_CTRL, 8'h04);
      tick(8);
      check({15'h0, blank_n}, 16'h0000);
      @(posedge mclk);
      fire_b <= 1'b1;
      @(posedge mclk);
      fire_b <= 1'b0;
      tick(6);
      check({15'h0, blank_n}, 16'h0001);
      tick(6);
      check({15'h0, blank_n}, 16'h0000);
      $display("test blanking input done");
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      forever #10 mclk = ~mclk;
   end
   // the whole sequence needs well under 100k cycles
   initial begin
      #2000000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      cfg = '0;
      cfg.lines_per_field = 10'd8;
      cfg.last_active_line = 10'd7;
      cfg.port_b_pulse_start = 11'd200;
      cfg.port_b_pulse_end = 11'd210;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      rd(`VSPT_ADDR_CTRL, 8'h00);
      rd(`VSPT_ADDR_TRIG_LO, 8'h00);
      rd(`VSPT_ADDR_TRIG_HI, 8'h00);
      rd(8'h67, 8'h00);
      check({14'h0, a_oe, b_oe}, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         wr(`VSPT_ADDR_CTRL, {2'(k), 6'h2a});
         rd(`VSPT_ADDR_CTRL, {2'(k), 6'h2a});
      end
      wr(`VSPT_ADDR_TRIG_HI, 8'hb5);
      rd(`VSPT_ADDR_TRIG_HI, 8'hb5);
      wr(8'h67, 8'h55);
      rd(8'h67, 8'h00);
      $display("test registers done");
      trig(8'h00, 1'b0, 11'd79, 1'b1);
      trig(8'h00, 1'b0, 11'd70, 1'b1);
      trig(8'h08, 1'b0, 11'd79, 1'b1);
      trig(8'h20, 1'b1, 11'd100, 1'b1);
      trig(8'h21, 1'b1, 11'd100, 1'b1);
      trig(8'h20, 1'b0, 11'd79, 1'b0);
      @(posedge mclk);
      cfg.embedded_sync_select <= 1'b1;
      trig(8'h20, 1'b1, 11'd100, 1'b0);
      @(posedge mclk);
      cfg.embedded_sync_select <= 1'b0;
      emb_chk(11'h04f);
      len_chk(1'b0, 11'h360);
      len_chk(1'b1, 11'h35a);
      pb(8'h02, 1'b1);
      pb(8'h03, 1'b1);
      @(posedge mclk);
      cfg.first_active_line <= 10'd100;
      cfg.last_active_line <= 10'd200;
      pb(8'h06, 1'b0);
      @(posedge mclk);
      cfg.first_active_line <= 10'd0;
      cfg.last_active_line <= 10'd7;
      pb(8'h06, 1'b1);
      pa(8'h10, 1'b1);
      pa(8'h18, 1'b1);
      pa(8'hd0, 1'b0);
      // shorten the field only while the line is below the new wrap point
      wait_line(10'd1);
      @(posedge mclk);
      cfg.lines_per_field <= 10'd4;
      pa_cnt(8'h90, 4, 1);
      pa_cnt(8'h50, 2, 1);
      blk();
      give_verdict();
   end
endmodule
`default_nettype wire
